// [fetx_pkg.sv]
// Shared constants for the fast Ethernet transmit coding path.
// Assumes one management port on core_clk and one serial clock domain at the line side.
`default_nettype none

package fetx_pkg;

	// Management register offsets.
	localparam logic [4:0] AUX_MODE_ADDR = 5'h12;
	localparam logic [4:0] RESULT_CTL_ADDR = 5'h13;

	// Auxiliary mode field positions.
	localparam int BLOCK_GATE_BIT = 1;
	localparam int LINK_IND_DIS_BIT = 3;
	localparam int ACT_IND_DIS_BIT = 4;

	// Negotiation result and control field positions.
	localparam int RX_ERR_CODE_BIT = 0;
	localparam int ISOLATE_BIT = 3;
	localparam int WAIT_ABILITY_BIT = 4;
	localparam int ACK_SEEN_BIT = 5;
	localparam int LINK_CHECK_BIT = 6;
	localparam int DONE_BIT = 7;
	localparam int RESTART_BIT = 8;
	localparam int SLOW_HALF_BIT = 11;
	localparam int SLOW_FULL_BIT = 12;
	localparam int FAST_HALF_BIT = 13;
	localparam int FOUR_PAIR_BIT = 14;
	localparam int FAST_FULL_BIT = 15;

	// Reset values of the writable fields.
	localparam logic [2:0] AUX_MODE_RESET = 3'h0;
	localparam logic [3:0] PHY_CTL_RESET = 4'h0;

	// Serial bits per code-group and the cycle in which a code-group is loaded.
	localparam logic [2:0] BITS_PER_GROUP = 3'h5;
	localparam logic [2:0] LOAD_PHASE = 3'h1;

	// Scrambler seed, loaded when the line side leaves reset.
	localparam logic [9:0] SCRAMBLER_SEED = 10'h3FF;

	// Special code-groups.
	localparam logic [4:0] CG_IDLE = 5'h1F;
	localparam logic [4:0] CG_J = 5'h18;
	localparam logic [4:0] CG_K = 5'h11;
	localparam logic [4:0] CG_T = 5'h0D;
	localparam logic [4:0] CG_R = 5'h07;

	// Transmit stream states.
	typedef enum logic [1:0] {TX_IDLE, TX_SEND_K, TX_DATA, TX_SEND_R} fetx_tx_state_type;

	// Negotiation progress states.
	typedef enum logic [1:0] {AN_WAIT_ABILITY, AN_WAIT_ACK, AN_LINK_CHECK, AN_DONE} fetx_an_state_type;

	// Data nibble to code-group mapping.
	function automatic logic [4:0] fetx_encode(input logic [3:0] nib);
		logic [4:0] cg;
		cg = 5'h00;
		case (nib)
			4'h0: cg = 5'h1E;
			4'h1: cg = 5'h09;
			4'h2: cg = 5'h14;
			4'h3: cg = 5'h15;
			4'h4: cg = 5'h0A;
			4'h5: cg = 5'h0B;
			4'h6: cg = 5'h0E;
			4'h7: cg = 5'h0F;
			4'h8: cg = 5'h12;
			4'h9: cg = 5'h13;
			4'hA: cg = 5'h16;
			4'hB: cg = 5'h17;
			4'hC: cg = 5'h1A;
			4'hD: cg = 5'h1B;
			4'hE: cg = 5'h1C;
			default: cg = 5'h1D;
		endcase
		return cg;
	endfunction

endpackage

`default_nettype wire

// [fetx_coding_path.sv]
// Transmit coding path: nibble capture, code-group mapping, delimiters, scrambling,
// serialisation, NRZI and MLT3, plus the two management registers it owns.
// Assumes ser_clk is the 125 MHz serial clock and the MAC samples tx_clk_out.
`timescale 1ns/1ns
`default_nettype none

module fetx_coding_path
	import fetx_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic ser_clk,
	input wire logic [4:0] mgmt_addr,
	input wire logic mgmt_wr,
	input wire logic [15:0] mgmt_wdata,
	output logic [15:0] mgmt_rdata,
	input wire logic tx_en,
	input wire logic [3:0] txd,
	output logic tx_clk_out,
	input wire logic nrzi_enable,
	output logic mlt3_pos,
	output logic mlt3_neg,
	input wire logic [3:0] partner_ability,
	input wire logic partner_ack,
	input wire logic partner_link_good,
	input wire logic rx_active,
	output logic link_led,
	output logic tx_activity_led,
	output logic rx_activity_led,
	output logic receive_error_code_mode
);
	import fetx_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Management registers on core_clk.

	logic [2:0] aux_mode; // Bits 4, 3 and 1 of the auxiliary mode register.
	logic [2:0] phy_ctl; // Bits 3 to 1 of the control register.
	logic negotiation_restart; // Self-clearing restart request.
	fetx_an_state_type an_state; // Negotiation progress.
	logic [3:0] result; // Fast full, fast half, slow full, slow half.
	logic [3:0] ability_meta, ability_s; // Partner ability synchroniser.
	logic [2:0] an_meta, an_s; // Ack, link good and receive activity.
	logic tx_act_meta, tx_act_s; // Frame activity from the line side.
	logic restart_write; // A write asking for a restart.
	logic tx_active; // Line side is past idle; crosses to core_clk through two flip-flops.

	assign restart_write = mgmt_wr && (mgmt_addr == RESULT_CTL_ADDR) && mgmt_wdata[RESTART_BIT];

	// Pins pass two flip-flops before anything reads them.
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			ability_meta <= 4'h0;
			ability_s <= 4'h0;
			an_meta <= 3'h0;
			an_s <= 3'h0;
			tx_act_meta <= 1'b0;
			tx_act_s <= 1'b0;
		end
		else
		begin
			ability_meta <= partner_ability;
			ability_s <= ability_meta;
			an_meta <= {rx_active, partner_link_good, partner_ack};
			an_s <= an_meta;
			tx_act_meta <= tx_active;
			tx_act_s <= tx_act_meta;
		end
	end

	// Writable fields; reserved bits are dropped and read back as zero.
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			aux_mode <= AUX_MODE_RESET;
			phy_ctl <= PHY_CTL_RESET[3:1];
			receive_error_code_mode <= PHY_CTL_RESET[0];
		end
		else if (mgmt_wr && mgmt_addr == AUX_MODE_ADDR)
		begin
			aux_mode <= {mgmt_wdata[ACT_IND_DIS_BIT], mgmt_wdata[LINK_IND_DIS_BIT],
				mgmt_wdata[BLOCK_GATE_BIT]};
		end
		else if (mgmt_wr && mgmt_addr == RESULT_CTL_ADDR)
		begin
			phy_ctl <= mgmt_wdata[ISOLATE_BIT:1];
			receive_error_code_mode <= mgmt_wdata[RX_ERR_CODE_BIT];
		end
	end

	// A restart is held for one cycle; a new write in the clearing cycle wins.
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			negotiation_restart <= 1'b0;
		end
		else if (restart_write)
		begin
			negotiation_restart <= 1'b1;
		end
		else
		begin
			negotiation_restart <= 1'b0;
		end
	end

	// Negotiation sequencer: ability, acknowledge, link check, done.
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			an_state <= AN_WAIT_ABILITY;
			result <= 4'h0;
		end
		else if (negotiation_restart)
		begin
			an_state <= AN_WAIT_ABILITY;
			result <= 4'h0;
		end
		else
		begin
			case (an_state)
				AN_WAIT_ABILITY:
				begin
					if (ability_s != 4'h0)
						an_state <= AN_WAIT_ACK;
				end
				AN_WAIT_ACK:
				begin
					if (an_s[0])
						an_state <= AN_LINK_CHECK;
				end
				AN_LINK_CHECK:
				begin
					// Highest partner ability wins, fast full duplex first.
					if (an_s[1])
					begin
						an_state <= AN_DONE;
						if (ability_s[3])
							result <= 4'h8;
						else if (ability_s[2])
							result <= 4'h4;
						else if (ability_s[1])
							result <= 4'h2;
						else
							result <= 4'h1;
					end
				end
				default:
				begin
					an_state <= AN_DONE;
				end
			endcase
		end
	end

	// Read data is registered and shows the addressed register one cycle later.
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			mgmt_rdata <= 16'h0000;
		else if (mgmt_addr == AUX_MODE_ADDR)
			mgmt_rdata <= {11'h000, aux_mode[2], aux_mode[1], 1'b0, aux_mode[0], 1'b0};
		else if (mgmt_addr == RESULT_CTL_ADDR)
			mgmt_rdata <= {result[3], 1'b0, result[2], result[1], result[0],
				2'h0, negotiation_restart,
				an_state == AN_DONE, an_state == AN_LINK_CHECK,
				an_state == AN_LINK_CHECK || an_state == AN_DONE,
				an_state == AN_WAIT_ABILITY,
				phy_ctl, receive_error_code_mode};
		else
			mgmt_rdata <= 16'h0000;
	end

	// Indicator outputs, each gated by its disable bit.
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			link_led <= 1'b0;
			tx_activity_led <= 1'b0;
			rx_activity_led <= 1'b0;
		end
		else
		begin
			link_led <= (an_state == AN_DONE) && !aux_mode[1];
			tx_activity_led <= tx_act_s && !aux_mode[2];
			rx_activity_led <= an_s[2] && !aux_mode[2];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Line side on ser_clk.

	logic ser_rst_meta, ser_reset; // Reset release synchroniser.
	logic [2:0] phase; // Bit position within the code-group.
	logic slot_load; // Cycle in which a code-group is chosen.
	logic [4:0] in_meta, in_s; // Transmit enable and nibble synchroniser.
	logic [1:0] cfg_meta, cfg_s; // Block gate and NRZI enable.
	logic frame_req; // MAC presents frame data.
	fetx_tx_state_type tx_state;
	logic [4:0] cg_reg; // Code-group being sent.
	logic [4:0] shreg; // Serialiser.
	logic [10:0] lfsr; // Stream cipher state.
	logic scr_bit, nrzi_q;
	logic [1:0] mlt3_step; // Zero, plus, zero, minus.

	// Reset asserts at once and releases on ser_clk.
	always_ff @(posedge ser_clk or posedge reset)
	begin
		if (reset)
		begin
			ser_rst_meta <= 1'b1;
			ser_reset <= 1'b1;
		end
		else
		begin
			ser_rst_meta <= 1'b0;
			ser_reset <= ser_rst_meta;
		end
	end

	// Divide by five; tx_clk_out rises as the phase returns to zero.
	always_ff @(posedge ser_clk or posedge ser_reset)
	begin
		if (ser_reset)
		begin
			phase <= 3'h0;
			tx_clk_out <= 1'b0;
		end
		else
		begin
			phase <= (phase == BITS_PER_GROUP - 3'h1) ? 3'h0 : phase + 3'h1;
			tx_clk_out <= (phase == BITS_PER_GROUP - 3'h1) || (phase == 3'h0);
		end
	end

	// The nibble seen at the rising edge reaches in_s exactly at the load phase.
	always_ff @(posedge ser_clk or posedge ser_reset)
	begin
		if (ser_reset)
		begin
			in_meta <= 5'h00;
			in_s <= 5'h00;
			cfg_meta <= 2'h0;
			cfg_s <= 2'h0;
		end
		else
		begin
			in_meta <= {tx_en, txd};
			in_s <= in_meta;
			cfg_meta <= {aux_mode[0], nrzi_enable};
			cfg_s <= cfg_meta;
		end
	end

	assign slot_load = (phase == LOAD_PHASE);
	assign frame_req = in_s[4] && !cfg_s[1];

	// Code-group choice: idle, J, K, data, T, R.
	always_ff @(posedge ser_clk or posedge ser_reset)
	begin
		if (ser_reset)
		begin
			tx_state <= TX_IDLE;
			cg_reg <= CG_IDLE;
		end
		else if (slot_load)
		begin
			case (tx_state)
				TX_IDLE:
				begin
					if (frame_req)
					begin
						cg_reg <= CG_J;
						tx_state <= TX_SEND_K;
					end
					else
					begin
						cg_reg <= CG_IDLE;
					end
				end
				TX_SEND_K:
				begin
					cg_reg <= CG_K;
					tx_state <= TX_DATA;
				end
				TX_DATA:
				begin
					if (frame_req)
					begin
						cg_reg <= fetx_encode(in_s[3:0]);
					end
					else
					begin
						cg_reg <= CG_T;
						tx_state <= TX_SEND_R;
					end
				end
				default:
				begin
					cg_reg <= CG_R;
					tx_state <= TX_IDLE;
				end
			endcase
		end
	end

	// Serialiser, most significant bit first; a frame counts active past idle.
	always_ff @(posedge ser_clk or posedge ser_reset)
	begin
		if (ser_reset)
		begin
			shreg <= CG_IDLE;
			tx_active <= 1'b0;
		end
		else
		begin
			shreg <= (phase == LOAD_PHASE + 3'h1) ? cg_reg : {shreg[3:0], 1'b0};
			tx_active <= (tx_state != TX_IDLE);
		end
	end

	// Scrambler x^11 + x^9 + 1, seeded at start, XORed onto every bit.
	always_ff @(posedge ser_clk or posedge ser_reset)
	begin
		if (ser_reset)
		begin
			lfsr <= {1'b0, SCRAMBLER_SEED};
			scr_bit <= 1'b0;
		end
		else
		begin
			lfsr <= {lfsr[9:0], lfsr[10] ^ lfsr[8]};
			scr_bit <= shreg[4] ^ lfsr[10] ^ lfsr[8];
		end
	end

	// NRZI toggles on ones, or passes the bit when disabled.
	always_ff @(posedge ser_clk or posedge ser_reset)
	begin
		if (ser_reset)
			nrzi_q <= 1'b0;
		else if (cfg_s[0])
			nrzi_q <= nrzi_q ^ scr_bit;
		else
			nrzi_q <= scr_bit;
	end

	// MLT3 holds on zero and steps cyclically on one.
	always_ff @(posedge ser_clk or posedge ser_reset)
	begin
		if (ser_reset)
		begin
			mlt3_step <= 2'h0;
			mlt3_pos <= 1'b0;
			mlt3_neg <= 1'b0;
		end
		else if (nrzi_q)
		begin
			mlt3_step <= mlt3_step + 2'h1;
			mlt3_pos <= (mlt3_step == 2'h0);
			mlt3_neg <= (mlt3_step == 2'h2);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	AST_IDLE_FILL: assert property (@(posedge ser_clk) disable iff (ser_reset)
		slot_load && tx_state == TX_IDLE && !frame_req |=> cg_reg == CG_IDLE)
		else $error("idle not sent between frames");
	AST_SSD: assert property (@(posedge ser_clk) disable iff (ser_reset)
		slot_load && tx_state == TX_IDLE && frame_req |=> (cg_reg == CG_J)[*5] ##1 cg_reg == CG_K)
		else $error("start delimiter wrong");
	AST_ESD: assert property (@(posedge ser_clk) disable iff (ser_reset)
		slot_load && tx_state == TX_DATA && !frame_req |=> (cg_reg == CG_T)[*5] ##1 cg_reg == CG_R)
		else $error("end delimiter wrong");
	AST_ENCODE: assert property (@(posedge ser_clk) disable iff (ser_reset)
		slot_load && tx_state == TX_DATA && frame_req |=> cg_reg == fetx_encode($past(in_s[3:0])))
		else $error("data code-group wrong");
	AST_GROUP_RATE: assert property (@(posedge ser_clk) disable iff (ser_reset)
		slot_load |=> !slot_load [*4] ##1 slot_load)
		else $error("code-group period not five bits");
	AST_SCRAMBLER_LIVE: assert property (@(posedge ser_clk) disable iff (ser_reset)
		lfsr != 11'h000)
		else $error("scrambler stuck at zero");
	AST_NRZI: assert property (@(posedge ser_clk) disable iff (ser_reset)
		##1 nrzi_q == ($past(cfg_s[0]) ? ($past(nrzi_q) ^ $past(scr_bit)) : $past(scr_bit)))
		else $error("nrzi conversion wrong");
	AST_MLT3_HOLD: assert property (@(posedge ser_clk) disable iff (ser_reset)
		!nrzi_q |=> $stable({mlt3_pos, mlt3_neg}) && !(mlt3_pos && mlt3_neg))
		else $error("mlt3 moved on a zero");
	AST_RESTART: assert property (@(posedge core_clk) disable iff (reset)
		restart_write |=> negotiation_restart ##1 an_state == AN_WAIT_ABILITY)
		else $error("restart not taken");
	AST_FOUR_PAIR: assert property (@(posedge core_clk) disable iff (reset)
		$past(mgmt_addr) == RESULT_CTL_ADDR |-> !mgmt_rdata[FOUR_PAIR_BIT])
		else $error("four-pair flag set");
	AST_LINK_LED: assert property (@(posedge core_clk) disable iff (reset)
		aux_mode[1] |=> !link_led)
		else $error("link indicator not suppressed");
	AST_ACT_LED: assert property (@(posedge core_clk) disable iff (reset)
		aux_mode[2] |=> !tx_activity_led && !rx_activity_led)
		else $error("activity indicator not suppressed");

	COV_FRAME_START: cover property (@(posedge ser_clk) disable iff (ser_reset)
		cg_reg == CG_J ##5 cg_reg == CG_K);
	COV_FRAME_END: cover property (@(posedge ser_clk) disable iff (ser_reset)
		cg_reg == CG_T ##5 cg_reg == CG_R);
	COV_NEG_DONE: cover property (@(posedge core_clk) disable iff (reset)
		an_state == AN_LINK_CHECK ##1 an_state == AN_DONE);
	COV_RESTART: cover property (@(posedge core_clk) disable iff (reset)
		an_state == AN_DONE && restart_write);

endmodule

`default_nettype wire

// [fetx_mac_model.sv]
// Behavioural media access controller on the transmit side of the nibble interface.
// Assumes tx_clk is the coding path's transmit clock and nibbles are taken on its rise.
`timescale 1ns/1ns
`default_nettype none
module fetx_mac_model
(
	input wire logic tx_clk,
	output logic tx_en,
	output logic [3:0] txd
);
	////////////////////////////////////////
	// Outputs are quiet and defined from time zero.
	initial
	begin
		tx_en = 1'b0;
		txd = 4'hA;
	end

	// Nibble k of a frame: fifteen preamble nibbles, a start nibble, then a counting pattern.
	function automatic logic [3:0] nib(input int k);
		return (k < 15) ? 4'h5 : (k == 15) ? 4'hD : k[3:0];
	endfunction

	////////////////////////////////////////
	// Sends one frame of n nibbles, changing the lines just after each transmit clock rise.
	// The data lines are inverted after the frame so a stale nibble never looks valid.
	task automatic send(input int n);
		for (int k = 0; k < n; k++)
		begin
			@(posedge tx_clk);
			#1;
			tx_en = 1'b1;
			txd = nib(k);
		end
		@(posedge tx_clk);
		#1;
		tx_en = 1'b0;
		txd = ~txd;
	endtask
endmodule
`default_nettype wire

// [fast_eth_tx_coding_path_bench.sv]
// Self-checking bench: registers, negotiation, indicators and the decoded line stream.
// Assumes the MAC model drives the nibble side and the serial clock runs freely.
`timescale 1ns/1ns
`default_nettype none
module fast_eth_tx_coding_path_bench;
	import fetx_pkg::*;
	logic core_clk, reset, ser_clk, mgmt_wr, tx_en, tx_clk_out, nrzi_enable;
	logic [4:0] mgmt_addr;
	logic [15:0] mgmt_wdata, mgmt_rdata;
	logic [3:0] txd, partner_ability;
	logic partner_ack, partner_link_good, rx_active, mlt3_pos, mlt3_neg;
	logic link_led, tx_activity_led, rx_activity_led, receive_error_code_mode;
	int fails = 0;
	int total_checks = 0;
	// Data code-groups indexed by nibble, kept apart from the design's own table.
	localparam logic [4:0] enc_tab [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
		5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
	localparam logic [3:0] abil [4] = '{4'hF, 4'h6, 4'h3, 4'h1};
	localparam logic [15:0] res [4] = '{16'h8000, 16'h2000, 16'h1000, 16'h0800};

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// The serial clock is offset so its edges never meet the bench's drive instants.
	initial
	begin
		ser_clk = 1'b0;
		#7;
		forever #24 ser_clk = ~ser_clk;
	end

	fetx_coding_path DUT (.core_clk(core_clk), .reset(reset), .ser_clk(ser_clk),
		.mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata),
		.mgmt_rdata(mgmt_rdata), .tx_en(tx_en), .txd(txd), .tx_clk_out(tx_clk_out),
		.nrzi_enable(nrzi_enable), .mlt3_pos(mlt3_pos), .mlt3_neg(mlt3_neg),
		.partner_ability(partner_ability), .partner_ack(partner_ack),
		.partner_link_good(partner_link_good), .rx_active(rx_active), .link_led(link_led),
		.tx_activity_led(tx_activity_led), .rx_activity_led(rx_activity_led),
		.receive_error_code_mode(receive_error_code_mode));
	fetx_mac_model mac (.tx_clk(tx_clk_out), .tx_en(tx_en), .txd(txd));

	////////////////////////////////////////
	// Line monitor: undoes the three-level code and the line code, learns the keystream
	// from idle, then descrambles and cuts frames at the start delimiter.
	// Learning assumes idle at start; a later slip of keystream shows up as stray zeros.
	logic [1:0] plv = 2'b00, lastnz = 2'b01, lv;
	logic [10:0] h;
	logic [9:0] win = 10'h3FF;
	logic [4:0] grp;
	logic pc = 1'b0, mon_go = 1'b0, nrzi_mon = 1'b1, in_frame = 1'b0, was_t = 1'b0, c, s, d;
	int lk = 0, bc = 0, zeros = 0, frames = 0, mlt_bad = 0;
	logic [4:0] rxq [$];
	always @(negedge ser_clk)
	begin
		lv = {mlt3_pos, mlt3_neg};
		c = (lv !== plv);
		if (c && ((plv == 2'b00) ? (lv !== ~lastnz) : (lv !== 2'b00)))
			mlt_bad++;
		if (lv != 2'b00)
			lastnz = lv;
		plv = lv;
		s = nrzi_mon ? (c ^ pc) : c;
		pc = c;
		if (mon_go && lk < 13)
		begin
			if (lk >= 2)
				h = {h[9:0], ~s};
			lk++;
		end
		else if (mon_go)
		begin
			d = s ^ h[10] ^ h[8];
			h = {h[9:0], h[10] ^ h[8]};
			if (!in_frame)
			begin
				win = {win[8:0], d};
				zeros += int'(!d);
				// Both delimiters carry six zeros between them.
				if (win == {CG_J, CG_K})
				begin
					in_frame = 1'b1;
					zeros -= 6;
					bc = 0;
				end
			end
			else
			begin
				grp = {grp[3:0], d};
				bc++;
				if (bc == 5)
				begin
					bc = 0;
					rxq.push_back(grp);
					if (was_t && grp == CG_R)
					begin
						in_frame = 1'b0;
						frames++;
						win = 10'h3FF;
					end
					was_t = (grp == CG_T);
				end
			end
		end
	end

	////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		idle(1);
		mgmt_addr = a;
		mgmt_wdata = v;
		mgmt_wr = 1'b1;
		idle(1);
		mgmt_wr = 1'b0;
	endtask
	// Read data trails the address by one cycle; three edges leave room to settle.
	task automatic rd(input logic [4:0] a, input logic [15:0] m, input logic [15:0] exp);
		idle(1);
		mgmt_addr = a;
		idle(3);
		chk(mgmt_rdata & m, exp);
	endtask
	// One frame from the MAC; the decoded groups must be the codes of nibbles 2 onward, then T and R.
	task automatic frame(input int n, input int nf);
		int f0;
		f0 = frames;
		rxq.delete();
		mac.send(n);
		for (int i = 0; i < 300 && frames == f0; i++)
			idle(1);
		chk(16'(frames - f0), 16'(nf));
		chk(16'(zeros), 16'h0000);
		if (nf == 1 && rxq.size() == n)
		begin
			for (int k = 2; k < n; k++)
				chk({11'h0, rxq[k - 2]}, {11'h0, enc_tab[mac.nib(k)]});
			chk({6'h0, rxq[n - 2], rxq[n - 1]}, {6'h0, CG_T, CG_R});
		end
		else
			chk(16'(rxq.size()), 16'(n * nf));
	endtask
	task automatic frame_led(input int n, input logic exp);
		fork
			frame(n, 1);
			begin
				idle(300);
				chk({15'h0, tx_activity_led}, {15'h0, exp});
			end
		join
	endtask
	task automatic results();
		if (fails == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	////////////////////////////////////////
	initial
	begin
		#300000;
		fails++;
		results();
	end
	initial
	begin
		reset = 1'b1;
		mgmt_addr = 5'h00;
		mgmt_wr = 1'b0;
		mgmt_wdata = 16'h0000;
		nrzi_enable = 1'b1;
		partner_ability = 4'h0;
		partner_ack = 1'b0;
		partner_link_good = 1'b0;
		rx_active = 1'b0;
		idle(12);
		reset = 1'b0;
		idle(100);
		mon_go = 1'b1;
		rd(5'h05, 16'hFFFF, 16'h0000);
		rd(AUX_MODE_ADDR, 16'hFFFF, 16'h0000);
		rd(RESULT_CTL_ADDR, 16'hFFFF, 16'h0010);
		wr(AUX_MODE_ADDR, 16'hFFFF);
		rd(AUX_MODE_ADDR, 16'hFFFF, 16'h001A);
		wr(AUX_MODE_ADDR, 16'h0000);
		wr(RESULT_CTL_ADDR, 16'h00FF);
		rd(RESULT_CTL_ADDR, 16'hFFFF, 16'h001F);
		chk({15'h0, receive_error_code_mode}, 16'h0001);
		wr(RESULT_CTL_ADDR, 16'h0000);
		rd(RESULT_CTL_ADDR, 16'hFFFF, 16'h0010);
		chk({15'h0, receive_error_code_mode}, 16'h0000);
		// Every result code in turn, each after a restart with the partner silent.
		for (int i = 0; i < 4; i++)
		begin
			partner_ability = 4'h0;
			partner_ack = 1'b0;
			partner_link_good = 1'b0;
			wr(RESULT_CTL_ADDR, 16'h0100);
			rd(RESULT_CTL_ADDR, 16'hF9F0, 16'h0010);
			partner_ability = abil[i];
			partner_ack = 1'b1;
			idle(12);
			rd(RESULT_CTL_ADDR, 16'h00F0, 16'h0060);
			partner_link_good = 1'b1;
			idle(12);
			rd(RESULT_CTL_ADDR, 16'hF890, 16'h0080 | res[i]);
		end
		wr(RESULT_CTL_ADDR, 16'h0000);
		rd(RESULT_CTL_ADDR, 16'hF890, 16'h0880);
		chk({15'h0, link_led}, 16'h0001);
		wr(AUX_MODE_ADDR, 16'h0008);
		idle(4);
		chk({15'h0, link_led}, 16'h0000);
		rx_active = 1'b1;
		wr(AUX_MODE_ADDR, 16'h0000);
		idle(8);
		chk({15'h0, rx_activity_led}, 16'h0001);
		wr(AUX_MODE_ADDR, 16'h0010);
		idle(4);
		chk({15'h0, rx_activity_led}, 16'h0000);
		wr(AUX_MODE_ADDR, 16'h0000);
		frame_led(32, 1'b1);
		wr(AUX_MODE_ADDR, 16'h0002);
		frame(24, 0);
		// Line code bypass: let the switch-over pass, then forget its stray bits.
		wr(AUX_MODE_ADDR, 16'h0010);
		nrzi_enable = 1'b0;
		nrzi_mon = 1'b0;
		idle(50);
		zeros = 0;
		win = 10'h3FF;
		frame_led(20, 1'b0);
		chk(16'(mlt_bad), 16'h0000);
		results();
	end
endmodule
`default_nettype wire
